/* File: logic/gcfg_cfg.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the configuration block.
// Assumes: Included by bare name from the design files.
// Notes: Function list follows.
// Function
// - Power-up clears registers except documented defaults.
// - Write address is register address plus 0x80.
// - Status flags clear only on written one.
// - Recalibrate while driver disabled by pin or off-time.
// - Standstill after 2^18 or 2^20 stepless clocks.
// - Bit 2 enables voltage-PWM mode; host switches carefully.
// - Bit 3 enables step filtering, default one.
// - Bit 4 inverts motor direction.
// - Bit 5 puts driver errors on output A.
// - Output A held low during reset.
// - Bit 6 puts temperature prewarning on output A.
// - Bit 7 puts stall on output A.
// - Bit 8 puts stall on output B.
// - Bit 9 puts table start on output B.
// - Bit 10 puts chopper on-state on output B.
// - Bit 11 toggles output B on lost steps.
// - Bit 12 selects output A drive style.
// - Bit 13 selects output B drive style.
// - Datagram is last 40 bits before select rise.
`ifndef GCFG_CFG_SVH
`define GCFG_CFG_SVH
`define GCFG_FRAME_BITS      40
`define GCFG_WRITE_FLAG      8'h80
`define GCFG_ADDR_CONFIG     7'h00
`define GCFG_ADDR_STATUS     7'h01
`define GCFG_CONFIG_WIDTH    18
`define GCFG_CONFIG_RESET    18'h00008
`define GCFG_STATUS_RESET    3'h1
`define GCFG_BIT_RECAL       0
`define GCFG_BIT_FAST_STILL  1
`define GCFG_BIT_PWM_MODE    2
`define GCFG_BIT_STEP_FILT   3
`define GCFG_BIT_DIR_INVERT  4
`define GCFG_BIT_A_ERROR     5
`define GCFG_BIT_A_PREWARN   6
`define GCFG_BIT_A_STALL     7
`define GCFG_BIT_B_STALL     8
`define GCFG_BIT_B_TABLE     9
`define GCFG_BIT_B_CHOP      10
`define GCFG_BIT_B_LOST      11
`define GCFG_BIT_A_STYLE     12
`define GCFG_BIT_B_STYLE     13
`define GCFG_STAT_RESET      0
`define GCFG_STAT_DRV_ERR    1
`define GCFG_STAT_CP_LOW     2
`define GCFG_STILL_SHORT     262144
`define GCFG_STILL_LONG      1048576
`endif

/* File: logic/gcfg_pkg.sv */
// Purpose: Types shared by the configuration block.
// Assumes: Nothing.
// Notes: Constants live in the cfg header.
package gcfg_pkg;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] data;
  } gcfg_cmd_type;

  typedef struct packed {
    logic overtemp_flag;
    logic short_to_ground;
    logic charge_pump_undervoltage;
    logic prewarning;
    logic stall;
    logic table_start;
    logic chopper_active;
    logic lost_step_inc;
  } gcfg_diag_src_type;
endpackage : gcfg_pkg

/* File: logic/gcfg_spi.sv */
// Purpose: Serial shift unit: 40-bit datagram capture and read-back shifting.
// Assumes: Serial pins are synchronous to the clock and slower than half its rate.
// Notes: Mode 3, sampled on rising clock edge, shifted on falling edge.
`timescale 1ns/100ps
`include "gcfg_cfg.svh"
module gcfg_spi (
  input  wire logic                 clk_in,
  input  wire logic                 arst_n_in,
  input  wire logic                 sck_in,
  input  wire logic                 sdi_in,
  input  wire logic                 csn_in,
  input  wire logic [39:0]          reply_in,
  output logic                      sdo_out,
  output logic                      cmd_valid_out,
  output gcfg_pkg::gcfg_cmd_type    cmd_out
);
  logic        sck_r, sck_nxt;
  logic        csn_r, csn_nxt;
  logic        bit_r, bit_nxt;
  logic [39:0] shift_r, shift_nxt;
  logic        lead_r, lead_nxt;
  logic        valid_r, valid_nxt;
  logic [39:0] cmd_r, cmd_nxt;

  always_comb begin
    sck_nxt   = sck_in;
    csn_nxt   = csn_in;
    bit_nxt   = bit_r;
    shift_nxt = shift_r;
    lead_nxt  = lead_r;
    valid_nxt = 1'b0;
    cmd_nxt   = cmd_r;
    if (csn_r && !csn_in) begin
      shift_nxt = reply_in;
      lead_nxt  = 1'b1;
    end else if (!csn_in && !sck_r && sck_in) begin
      bit_nxt = sdi_in;
    end else if (!csn_in && sck_r && !sck_in) begin
      // The first falling edge only presents the top reply bit, so it must not shift it away.
      lead_nxt = 1'b0;
      if (!lead_r) begin
        // Longer frames pass through and fall out on the serial output for daisy chains.
        shift_nxt = {shift_r[38:0], bit_r};
      end
    end
    if (!csn_r && csn_in) begin
      cmd_nxt   = {shift_r[38:0], bit_r};
      valid_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sck_r   <= 1'b1;
      csn_r   <= 1'b1;
      bit_r   <= 1'b0;
      shift_r <= 40'h0;
      lead_r  <= 1'b0;
      valid_r <= 1'b0;
      cmd_r   <= 40'h0;
    end else begin
      sck_r   <= sck_nxt;
      csn_r   <= csn_nxt;
      bit_r   <= bit_nxt;
      shift_r <= shift_nxt;
      lead_r  <= lead_nxt;
      valid_r <= valid_nxt;
      cmd_r   <= cmd_nxt;
    end
  end

  assign sdo_out       = shift_r[39];
  assign cmd_valid_out = valid_r;
  assign cmd_out       = cmd_r;
endmodule : gcfg_spi

/* File: logic/gcfg_top.sv */
// Purpose: Global configuration register with standstill detection and diagnostic outputs.
// Assumes: All inputs synchronous to REF_CLK_IN at 125 MHz.
// Notes: Read data of a datagram answers the address sent in the previous one.
`timescale 1ns/100ps
`include "gcfg_cfg.svh"
module gcfg_top #(
  parameter int unsigned STILL_SHORT = `GCFG_STILL_SHORT,
  parameter int unsigned STILL_LONG  = `GCFG_STILL_LONG
) (
  input  wire logic                       REF_CLK_IN,
  input  wire logic                       ARST_N_IN,
  input  wire logic                       SCK_IN,
  input  wire logic                       SDI_IN,
  input  wire logic                       CSN_IN,
  input  wire logic                       STEP_IN,
  input  wire logic                       DIR_IN,
  input  wire logic                       DRIVER_ENABLE_N_IN,
  input  wire logic                       OFF_TIME_ZERO_IN,
  input  wire gcfg_pkg::gcfg_diag_src_type DIAG_SRC_IN,
  output logic                            SDO_OUT,
  output logic                            DIAG_A_OUT,
  output logic                            DIAG_A_OE_OUT,
  output logic                            DIAG_B_OUT,
  output logic                            DIAG_B_OE_OUT,
  output logic                            MOTOR_DIR_OUT,
  output logic                            STANDSTILL_OUT,
  output logic                            RECAL_OUT,
  output logic                            PWM_MODE_OUT,
  output logic                            STEP_FILTER_OUT
);
  // The standstill counter is 21 bits wide, so longer timeouts cannot be served.
  if (STILL_SHORT == 0 || STILL_LONG == 0 || STILL_SHORT >= 32'h00200000 ||
      STILL_LONG >= 32'h00200000) begin : g_bad_timeout
    $error("Standstill timeouts must be between 1 and 2^21-1 clocks.");
  end

  logic                                  cmd_valid;
  gcfg_pkg::gcfg_cmd_type                cmd;
  logic [39:0]                           reply;
  logic [`GCFG_CONFIG_WIDTH-1:0]         config_r;
  logic [`GCFG_CONFIG_WIDTH-1:0]         config_nxt;
  logic [2:0]                            status_r;
  logic [2:0]                            status_nxt;
  logic [6:0]                            rd_addr_r;
  logic [6:0]                            rd_addr_nxt;
  logic [20:0]                           still_cnt_r;
  logic [20:0]                           still_cnt_nxt;
  logic                                  still_r;
  logic                                  still_nxt;
  logic                                  toggle_r;
  logic                                  toggle_nxt;
  logic                                  a_out_r;
  logic                                  a_out_nxt;
  logic                                  a_oe_r;
  logic                                  a_oe_nxt;
  logic                                  b_out_r;
  logic                                  b_out_nxt;
  logic                                  b_oe_r;
  logic                                  b_oe_nxt;
  logic                                  dir_r;
  logic                                  dir_nxt;
  logic                                  recal_r;
  logic                                  recal_nxt;
  logic                                  pwm_r;
  logic                                  pwm_nxt;
  logic                                  filt_r;
  logic                                  filt_nxt;
  logic [20:0]                           timeout;
  logic                                  a_active;
  logic                                  b_active;

  gcfg_spi u_spi (
    .clk_in        (REF_CLK_IN),
    .arst_n_in     (ARST_N_IN),
    .sck_in        (SCK_IN),
    .sdi_in        (SDI_IN),
    .csn_in        (CSN_IN),
    .reply_in      (reply),
    .sdo_out       (SDO_OUT),
    .cmd_valid_out (cmd_valid),
    .cmd_out       (cmd)
  );

  function automatic logic [31:0] read_word(input logic [6:0] addr,
                                            input logic [`GCFG_CONFIG_WIDTH-1:0] cfg,
                                            input logic [2:0] stat);
    logic [31:0] w;
    w = 32'h0;
    if (addr == `GCFG_ADDR_CONFIG) begin
      w = {14'h0, cfg};
    end else if (addr == `GCFG_ADDR_STATUS) begin
      w = {29'h0, stat};
    end
    return w;
  endfunction : read_word

  function automatic logic drive_style(input logic active, input logic push_pull,
                                       output logic oe);
    // Open collector pulls low when active and floats otherwise.
    oe = push_pull | active;
    return push_pull & active;
  endfunction : drive_style

  // Writes carry the register address with the write flag set on top.
  function automatic logic is_write(input logic [7:0] addr, input logic [6:0] reg_addr);
    return addr == (`GCFG_WRITE_FLAG | {1'b0, reg_addr});
  endfunction : is_write

  // Register file and status flags.
  always_comb begin
    config_nxt  = config_r;
    status_nxt  = status_r;
    rd_addr_nxt = rd_addr_r;
    if (cmd_valid) begin
      rd_addr_nxt = cmd.addr[6:0];
      if (is_write(cmd.addr, `GCFG_ADDR_CONFIG)) begin
        config_nxt = cmd.data[`GCFG_CONFIG_WIDTH-1:0];
      end else if (is_write(cmd.addr, `GCFG_ADDR_STATUS)) begin
        status_nxt = status_r & ~cmd.data[2:0];
      end
    end
    // A flag raised in the cycle of its clear stays set.
    status_nxt[`GCFG_STAT_DRV_ERR] = status_nxt[`GCFG_STAT_DRV_ERR] |
                                     DIAG_SRC_IN.overtemp_flag | DIAG_SRC_IN.short_to_ground;
    status_nxt[`GCFG_STAT_CP_LOW]  = status_nxt[`GCFG_STAT_CP_LOW] |
                                     DIAG_SRC_IN.charge_pump_undervoltage;
  end

  assign reply = {4'h0, still_r, DIAG_SRC_IN.stall, status_r[`GCFG_STAT_DRV_ERR],
                  status_r[`GCFG_STAT_RESET], read_word(rd_addr_r, config_r, status_r)};

  // Standstill timer, saturating once the timeout is reached.
  assign timeout = config_r[`GCFG_BIT_FAST_STILL] ? STILL_SHORT[20:0] : STILL_LONG[20:0];

  always_comb begin
    still_cnt_nxt = still_cnt_r;
    still_nxt     = still_r;
    if (STEP_IN) begin
      still_cnt_nxt = 21'h0;
      still_nxt     = 1'b0;
    end else if (still_cnt_r < timeout) begin
      still_cnt_nxt = still_cnt_r + 21'h1;
      still_nxt     = 1'b0;
    end else begin
      still_nxt = 1'b1;
    end
  end

  // Diagnostic outputs and driver controls.
  always_comb begin
    toggle_nxt = toggle_r ^ (DIAG_SRC_IN.lost_step_inc & config_r[`GCFG_BIT_B_LOST]);
    a_active = (config_r[`GCFG_BIT_A_ERROR] & (DIAG_SRC_IN.overtemp_flag |
                DIAG_SRC_IN.short_to_ground | DIAG_SRC_IN.charge_pump_undervoltage)) |
               (config_r[`GCFG_BIT_A_PREWARN] & DIAG_SRC_IN.prewarning) |
               (config_r[`GCFG_BIT_A_STALL] & DIAG_SRC_IN.stall);
    b_active = (config_r[`GCFG_BIT_B_STALL] & DIAG_SRC_IN.stall) |
               (config_r[`GCFG_BIT_B_TABLE] & DIAG_SRC_IN.table_start) |
               (config_r[`GCFG_BIT_B_CHOP] & DIAG_SRC_IN.chopper_active) |
               toggle_r;
    a_out_nxt = drive_style(a_active, config_r[`GCFG_BIT_A_STYLE], a_oe_nxt);
    b_out_nxt = drive_style(b_active, config_r[`GCFG_BIT_B_STYLE], b_oe_nxt);
    dir_nxt   = DIR_IN ^ config_r[`GCFG_BIT_DIR_INVERT];
    recal_nxt = config_r[`GCFG_BIT_RECAL] & (DRIVER_ENABLE_N_IN | OFF_TIME_ZERO_IN);
    // The host only turns this on at standstill with equal hold and run current.
    pwm_nxt   = config_r[`GCFG_BIT_PWM_MODE];
    filt_nxt  = config_r[`GCFG_BIT_STEP_FILT];
  end

  // Register file state.
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      config_r    <= `GCFG_CONFIG_RESET;
      status_r    <= `GCFG_STATUS_RESET;
      rd_addr_r   <= 7'h00;
    end else begin
      config_r    <= config_nxt;
      status_r    <= status_nxt;
      rd_addr_r   <= rd_addr_nxt;
    end
  end

  // Standstill timer state.
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      still_cnt_r <= 21'h0;
      still_r     <= 1'b0;
    end else begin
      still_cnt_r <= still_cnt_nxt;
      still_r     <= still_nxt;
    end
  end

  // Diagnostic and driver control state.
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      toggle_r    <= 1'b0;
      a_out_r     <= 1'b0;
      a_oe_r      <= 1'b1;
      b_out_r     <= 1'b0;
      b_oe_r      <= 1'b0;
      dir_r       <= 1'b0;
      recal_r     <= 1'b0;
      pwm_r       <= 1'b0;
      filt_r      <= 1'b1;
    end else begin
      toggle_r    <= toggle_nxt;
      a_out_r     <= a_out_nxt;
      a_oe_r      <= a_oe_nxt;
      b_out_r     <= b_out_nxt;
      b_oe_r      <= b_oe_nxt;
      dir_r       <= dir_nxt;
      recal_r     <= recal_nxt;
      pwm_r       <= pwm_nxt;
      filt_r      <= filt_nxt;
    end
  end

  assign DIAG_A_OUT      = a_out_r;
  assign DIAG_A_OE_OUT   = a_oe_r;
  assign DIAG_B_OUT      = b_out_r;
  assign DIAG_B_OE_OUT   = b_oe_r;
  assign MOTOR_DIR_OUT   = dir_r;
  assign STANDSTILL_OUT  = still_r;
  assign RECAL_OUT       = recal_r;
  assign PWM_MODE_OUT    = pwm_r;
  assign STEP_FILTER_OUT = filt_r;
endmodule : gcfg_top

/* File: bench/gcfg_properties.sv */
// Purpose: Port-level checks of the configuration block.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes: Config bits are hidden here, so checks lean on stability between frames.
`timescale 1ns/100ps
module gcfg_properties #(
  parameter int unsigned STILL_SHORT = 16,
  parameter int unsigned STILL_LONG  = 64
) (
  input wire logic REF_CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic CSN_IN,
  input wire logic STEP_IN,
  input wire logic DIR_IN,
  input wire logic DRIVER_ENABLE_N_IN,
  input wire logic OFF_TIME_ZERO_IN,
  input wire logic DIAG_A_OUT,
  input wire logic DIAG_A_OE_OUT,
  input wire logic DIAG_B_OUT,
  input wire logic DIAG_B_OE_OUT,
  input wire logic MOTOR_DIR_OUT,
  input wire logic STANDSTILL_OUT,
  input wire logic RECAL_OUT,
  input wire logic PWM_MODE_OUT,
  input wire logic STEP_FILTER_OUT
);
  logic        dir_r;
  int unsigned since_r;
  // The step counter saturates so a long idle stretch cannot wrap it.
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      dir_r   <= 1'h0;
      since_r <= 32'h0;
    end else begin
      dir_r   <= DIR_IN;
      since_r <= STEP_IN ? 32'h0 : (since_r > STILL_LONG ? since_r : since_r + 1);
    end
  end
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  a_dir_invert: assert property ($stable(CSN_IN)[*4] |-> $stable(MOTOR_DIR_OUT ^ dir_r))
    else $error("Direction changed with no frame.");
  a_pwm_hold: assert property ($stable(CSN_IN)[*4] |-> $stable(PWM_MODE_OUT))
    else $error("Voltage mode changed with no frame.");
  a_filter_hold: assert property ($stable(CSN_IN)[*4] |-> $stable(STEP_FILTER_OUT))
    else $error("Step filter changed with no frame.");
  a_diag_a_reset: assert property (@(posedge REF_CLK_IN) disable iff (1'h0)
    !ARST_N_IN |-> !DIAG_A_OUT && DIAG_A_OE_OUT) else $error("Output A not low in reset.");
  a_recal_idle: assert property (!$past(DRIVER_ENABLE_N_IN) && !$past(OFF_TIME_ZERO_IN)
    |-> !RECAL_OUT) else $error("Recalibration while driver enabled.");
  a_still_drop: assert property (STEP_IN |=> !STANDSTILL_OUT)
    else $error("Standstill kept after a step.");
  a_still_early: assert property ($rose(STANDSTILL_OUT) |-> since_r >= STILL_SHORT)
    else $error("Standstill came too early.");
  a_a_drive_legal: assert property (DIAG_A_OE_OUT || !DIAG_A_OUT)
    else $error("Output A high while undriven.");
  a_b_drive_legal: assert property (DIAG_B_OE_OUT || !DIAG_B_OUT)
    else $error("Output B high while undriven.");
  c_still: cover property ($rose(STANDSTILL_OUT));
  c_recal: cover property ($rose(RECAL_OUT));
  c_pwm: cover property ($rose(PWM_MODE_OUT));
endmodule : gcfg_properties
bind gcfg_top gcfg_properties #(.STILL_SHORT(STILL_SHORT), .STILL_LONG(STILL_LONG)) i_props (
  .REF_CLK_IN(REF_CLK_IN), .ARST_N_IN(ARST_N_IN), .CSN_IN(CSN_IN), .STEP_IN(STEP_IN),
  .DIR_IN(DIR_IN), .DRIVER_ENABLE_N_IN(DRIVER_ENABLE_N_IN), .OFF_TIME_ZERO_IN(OFF_TIME_ZERO_IN),
  .DIAG_A_OUT(DIAG_A_OUT), .DIAG_A_OE_OUT(DIAG_A_OE_OUT), .DIAG_B_OUT(DIAG_B_OUT),
  .DIAG_B_OE_OUT(DIAG_B_OE_OUT), .MOTOR_DIR_OUT(MOTOR_DIR_OUT), .STANDSTILL_OUT(STANDSTILL_OUT),
  .RECAL_OUT(RECAL_OUT), .PWM_MODE_OUT(PWM_MODE_OUT), .STEP_FILTER_OUT(STEP_FILTER_OUT));

/* File: bench/gcfg_host.sv */
// Purpose: Serial host model that sends one 40-bit datagram per call.
// Assumes: Mode 3 timing with slow serial clock edges.
// Notes: Serial clock stands high between frames; data line flips when idle.
`timescale 1ns/100ps
module gcfg_host (
  input  wire logic clk_in,
  input  wire logic sdo_in,
  output logic      sck_out,
  output logic      sdi_out,
  output logic      csn_out
);
  initial begin
    sck_out = 1'h1;
    sdi_out = 1'h0;
    csn_out = 1'h1;
  end
  task automatic xfer(input logic [39:0] tx, output logic [39:0] rx);
    @(negedge clk_in);
    csn_out = 1'h0;
    repeat (3) @(negedge clk_in);
    for (int i = 39; i >= 0; i--) begin
      sck_out = 1'h0;
      sdi_out = tx[i];
      repeat (4) @(negedge clk_in);
      sck_out = 1'h1;
      rx[i]   = sdo_in;
      repeat (3) @(negedge clk_in);
    end
    csn_out = 1'h1;
    // A stale level is not left behind, so nothing can rely on it.
    sdi_out = ~sdi_out;
    repeat (4) @(negedge clk_in);
  endtask : xfer
endmodule : gcfg_host

/* File: bench/tb.sv */
// Purpose: Self-checking bench of the configuration block.
// Assumes: Short standstill counts of 16 and 64 cycles.
// Notes: Inputs change on the falling clock edge, except the reset assertion.
`timescale 1ns/100ps
`define GCHK(w, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp %0h got %0h", w, e, g); end end
module tb;
  logic clk = 1'h0, rst_n = 1'h1, step = 1'h0, dir = 1'h0, en_n = 1'h0, off0 = 1'h0;
  logic sck, sdi, csn, sdo, a_o, a_oe, b_o, b_oe, mdir, still, recal, pwm, filt;
  gcfg_pkg::gcfg_diag_src_type src = '0;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  logic [39:0] rx;
  always #4 clk = ~clk;
  gcfg_host i_host (.clk_in(clk), .sdo_in(sdo), .sck_out(sck), .sdi_out(sdi), .csn_out(csn));
  gcfg_top #(.STILL_SHORT(16), .STILL_LONG(64)) i_dut (
    .REF_CLK_IN(clk), .ARST_N_IN(rst_n), .SCK_IN(sck), .SDI_IN(sdi), .CSN_IN(csn),
    .STEP_IN(step), .DIR_IN(dir), .DRIVER_ENABLE_N_IN(en_n), .OFF_TIME_ZERO_IN(off0),
    .DIAG_SRC_IN(src), .SDO_OUT(sdo), .DIAG_A_OUT(a_o), .DIAG_A_OE_OUT(a_oe),
    .DIAG_B_OUT(b_o), .DIAG_B_OE_OUT(b_oe), .MOTOR_DIR_OUT(mdir), .STANDSTILL_OUT(still),
    .RECAL_OUT(recal), .PWM_MODE_OUT(pwm), .STEP_FILTER_OUT(filt));
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    i_host.xfer({1'h1, a, d}, rx);
  endtask : wr
  // Read data comes back in the frame after the one that names the address.
  task automatic rd(input logic [6:0] a);
    i_host.xfer({1'h0, a, 32'h0}, rx);
    i_host.xfer(40'h0, rx);
  endtask : rd
  function automatic logic [1:0] pin(input logic act, input logic pp);
    return pp ? {act, 1'h1} : {1'h0, act};
  endfunction : pin
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic t_reset;
    // A real falling reset edge off the clock edge resets the flops before the first clock.
    #1 rst_n = 1'h0;
    repeat (4) @(negedge clk);
    `GCHK("diag_a_rst", 2'h1, {a_o, a_oe})
    rst_n = 1'h1;
    repeat (2) @(negedge clk);
    `GCHK("filter_rst", 1'h1, filt)
    rd(7'h00);
    `GCHK("cfg_rst", 32'h8, rx[31:0])
    `GCHK("stat_bits", 8'h09, rx[39:32])
  endtask : t_reset
  task automatic t_regs;
    wr(7'h00, 32'hfffe_a01c);
    `GCHK("pwm", 1'h1, pwm)
    `GCHK("dir_inv", 1'h1, mdir)
    `GCHK("diag_b_pp", 2'h1, {b_o, b_oe})
    dir = 1'h1;
    repeat (2) @(negedge clk);
    `GCHK("dir_inv1", 1'h0, mdir)
    wr(7'h05, 32'hffff_ffff);
    rd(7'h00);
    `GCHK("cfg_rw", 32'h2a01c, rx[31:0])
    rd(7'h05);
    `GCHK("unmapped", 32'h0, rx[31:0])
    wr(7'h00, 32'h0);
    `GCHK("filter_off", 1'h0, filt)
    `GCHK("dir_plain", 1'h1, mdir)
    `GCHK("pwm_off", 1'h0, pwm)
  endtask : t_regs
  task automatic t_status;
    wr(7'h01, 32'h0);
    rd(7'h01);
    `GCHK("stat_keep", 32'h1, rx[31:0])
    wr(7'h01, 32'h1);
    rd(7'h01);
    `GCHK("stat_clr", 32'h0, rx[31:0])
    // A driver error that persists through its clear must stay flagged.
    src.overtemp_flag = 1'h1;
    wr(7'h01, 32'h6);
    rd(7'h01);
    `GCHK("stat_set_wins", 32'h2, rx[31:0])
    `GCHK("stat_drv_err", 1'h1, rx[33])
    src = '0;
    wr(7'h01, 32'h2);
    rd(7'h01);
    `GCHK("stat_drv_clr", 32'h0, rx[31:0])
  endtask : t_status
  task automatic t_recal;
    wr(7'h00, 32'h1);
    for (int i = 0; i < 4; i++) begin
      {en_n, off0} = i[1:0];
      repeat (2) @(negedge clk);
      `GCHK("recal", i != 0, recal)
    end
    off0 = 1'h0;
    wr(7'h00, 32'h0);
    `GCHK("recal_off", 1'h0, recal)
    en_n = 1'h0;
  endtask : t_recal
  task automatic t_still;
    int n;
    for (int s = 0; s < 2; s++) begin
      wr(7'h00, {30'h0, s[0], 1'h0});
      step = 1'h1;
      @(negedge clk);
      step = 1'h0;
      n = 0;
      while (still !== 1'h1 && n < 200) begin
        @(negedge clk);
        n++;
      end
      `GCHK("still_cycles", s ? 17 : 65, n)
    end
  endtask : t_still
  task automatic t_diag;
    int sb[8] = '{7, 6, 5, 4, 3, 3, 2, 1};
    int cb[8] = '{5, 5, 5, 6, 7, 8, 9, 10};
    for (int s = 0; s < 2; s++) begin
      for (int k = 0; k < 8; k++) begin
        wr(7'h00, (32'h1 << cb[k]) | {18'h0, s[0], s[0], 12'h0});
        src[sb[k]] = 1'h1;
        repeat (2) @(negedge clk);
        `GCHK("diag_a", pin(cb[k] < 8, s[0]), {a_o, a_oe})
        `GCHK("diag_b", pin(cb[k] > 7, s[0]), {b_o, b_oe})
        src = '0;
        repeat (2) @(negedge clk);
        `GCHK("diag_idle", pin(1'h0, s[0]), {a_o, a_oe})
      end
    end
    wr(7'h00, 32'h2800);
    for (int t = 1; t >= 0; t--) begin
      src.lost_step_inc = 1'h1;
      @(negedge clk);
      src.lost_step_inc = 1'h0;
      repeat (3) @(negedge clk);
      `GCHK("diag_b_lost", {t[0], 1'h1}, {b_o, b_oe})
    end
  endtask : t_diag
  initial begin
    t_reset();
    t_regs();
    t_status();
    t_recal();
    t_still();
    t_diag();
    tally_and_finish();
  end
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule : tb
